// >>> hdl/gwc_regs.sv
/*
 * Pin wake, pending-flag and pad configuration register block.
 * Assumes a plain register port on clk_sys: one-cycle strobes,
 * read data valid the cycle after the read strobe. Pins are asynchronous.
 */
// The plain strobed port was decided locally.
// How it works
// R1 - Writing one to a clear-register bit clears that pin's pending flag; zero ignored.
// R2 - Wake enable bit one makes the pin a wakeup source; resets to zero.
// R3 - Ones written to the set alias set wake enable bits; zeros untouched.
// R4 - Ones written to the clear alias clear wake enable bits; zeros untouched.
// R5 - Two 32-bit read/write pad configuration registers select input mode and pulls.
// R6 - Function select low holds one bit per pin, resets zero, writable directly.
// R7 - Function select low never alters input path or interrupt detection.
// R8 - Software leaves function bits of unimplemented pins at reset value.
// R9 - Dual-edge mode register is 32-bit read/write, resets to zero.
// R10 - Pending flag sets on enabled condition and stays until software clears it.
// R11 - Polarity picks low/high level, or falling/rising edge.
// R12 - Dual-edge bit in edge mode makes both edges set pending, ignoring polarity.
`timescale 1ns/100ps
`include "gwc_defines.svh"
module gwc_regs
   import gwc_pkg::*;
#(
   parameter int PINS = 32
) (
   input  wire logic            clk_sys,
   input  wire logic            rst,
   input  wire logic [7:0]      reg_addr,
   input  wire logic [31:0]     reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic      [31:0]     reg_rdata,
   input  wire logic [PINS-1:0] pin_in,
   output logic      [PINS-1:0] wake_request,
   output logic      [PINS-1:0] pending_flags,
   output logic      [PINS-1:0] wake_enable,
   output logic      [PINS-1:0] pad_config_a,
   output logic      [PINS-1:0] pad_config_b,
   output logic      [PINS-1:0] function_select_low
);

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   if (PINS < 1 || PINS > 32) begin : g_bad_pins
      $error("PINS must be 1 to 32");
   end

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   gwc_req_s        req;
   logic [PINS-1:0] pin_sync;
   logic [PINS-1:0] hit;
   logic [PINS-1:0] trig_enable;
   logic [PINS-1:0] trig_mode;
   logic [PINS-1:0] trig_polarity;
   logic [PINS-1:0] both_edge_select;
   logic [PINS-1:0] next_pending_flags;
   logic [PINS-1:0] next_wake_enable;
   logic [PINS-1:0] next_trig_enable;
   logic [PINS-1:0] next_trig_mode;
   logic [PINS-1:0] next_trig_polarity;
   logic [PINS-1:0] next_both_edge_select;
   logic [PINS-1:0] next_pad_config_a;
   logic [PINS-1:0] next_pad_config_b;
   logic [PINS-1:0] next_function_select_low;
   logic [PINS-1:0] next_wake_request;
   logic [31:0]     next_reg_rdata;
   logic [PINS-1:0] wdata_p;

   assign req     = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
   assign wdata_p = req.wdata[PINS-1:0];

   // ----------------------------------------------------------------------
   // Pin synchronisation and per-pin detection
   // ----------------------------------------------------------------------
   gwc_sync #(
      .WIDTH    (PINS)
   ) u_sync (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   // Function select is deliberately not an input here, so muxing a pin
   // to an alternate function leaves its interrupt path intact.
   for (genvar i = 0; i < PINS; i++) begin : g_pin
      gwc_detect u_det (
         .clk_sys   (clk_sys),
         .rst       (rst),
         .pin_level (pin_sync[i]),
         .trig      ('{enable:     trig_enable[i],
                       edge_mode:  trig_mode[i],
                       polarity:   trig_polarity[i],
                       both_edges: both_edge_select[i]}),             // see R7
         .hit       (hit[i])
      );
   end

   // ----------------------------------------------------------------------
   // Register next values
   // ----------------------------------------------------------------------
   // Set wins over clear so an event landing on a clear write is not lost
   always_comb begin
      next_pending_flags       = pending_flags;
      next_wake_enable         = wake_enable;
      next_trig_enable         = trig_enable;
      next_trig_mode           = trig_mode;
      next_trig_polarity       = trig_polarity;
      next_both_edge_select    = both_edge_select;
      next_pad_config_a        = pad_config_a;
      next_pad_config_b        = pad_config_b;
      next_function_select_low = function_select_low;
      if (req.wr) begin
         unique case (req.addr)
            `GWC_OFS_PENDING_FLAG_CLEAR: begin
               next_pending_flags = pending_flags & ~wdata_p;              // see R1
            end
            `GWC_OFS_WAKE_ENABLE:       next_wake_enable = wdata_p;        // see R2
            `GWC_OFS_WAKE_ENABLE_SET:   next_wake_enable = wake_enable | wdata_p;  // see R3
            `GWC_OFS_WAKE_ENABLE_CLEAR: next_wake_enable = wake_enable & ~wdata_p; // see R4
            `GWC_OFS_TRIGGER_ENABLE:    next_trig_enable = wdata_p;
            `GWC_OFS_TRIGGER_MODE:      next_trig_mode = wdata_p;
            `GWC_OFS_TRIGGER_POLARITY:  next_trig_polarity = wdata_p;
            `GWC_OFS_BOTH_EDGE_SELECT:  next_both_edge_select = wdata_p;   // see R9
            `GWC_OFS_PAD_CONFIG_A:      next_pad_config_a = wdata_p;       // see R5
            `GWC_OFS_PAD_CONFIG_B:      next_pad_config_b = wdata_p;       // see R5
            `GWC_OFS_FUNCTION_SEL_LOW:  next_function_select_low = wdata_p; // see R6
            default: ;
         endcase
      end
      next_pending_flags = next_pending_flags | hit;                       // see R10
      // Wake is raised by a pending pin whose wake bit is on
      next_wake_request  = pending_flags & wake_enable;                    // see R2
   end

   // Read mux; unmapped and write-only offsets read zero
   always_comb begin
      next_reg_rdata = 32'h0000_0000;
      if (req.rd) begin
         unique case (req.addr)
            `GWC_OFS_PENDING_FLAGS:     next_reg_rdata[PINS-1:0] = pending_flags;
            `GWC_OFS_WAKE_ENABLE:       next_reg_rdata[PINS-1:0] = wake_enable;
            `GWC_OFS_TRIGGER_ENABLE:    next_reg_rdata[PINS-1:0] = trig_enable;
            `GWC_OFS_TRIGGER_MODE:      next_reg_rdata[PINS-1:0] = trig_mode;
            `GWC_OFS_TRIGGER_POLARITY:  next_reg_rdata[PINS-1:0] = trig_polarity;
            `GWC_OFS_BOTH_EDGE_SELECT:  next_reg_rdata[PINS-1:0] = both_edge_select;
            `GWC_OFS_PAD_CONFIG_A:      next_reg_rdata[PINS-1:0] = pad_config_a;
            `GWC_OFS_PAD_CONFIG_B:      next_reg_rdata[PINS-1:0] = pad_config_b;
            `GWC_OFS_FUNCTION_SEL_LOW:  next_reg_rdata[PINS-1:0] = function_select_low;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pending_flags       <= '0;
         wake_enable         <= '0;
         trig_enable         <= '0;
         trig_mode           <= '0;
         trig_polarity       <= '0;
         both_edge_select    <= '0;
         pad_config_a        <= '0;
         pad_config_b        <= '0;
         function_select_low <= '0;
         wake_request        <= '0;
         reg_rdata           <= `GWC_RST_ZERO;
      end else begin
         pending_flags       <= next_pending_flags;
         wake_enable         <= next_wake_enable;
         trig_enable         <= next_trig_enable;
         trig_mode           <= next_trig_mode;
         trig_polarity       <= next_trig_polarity;
         both_edge_select    <= next_both_edge_select;
         pad_config_a        <= next_pad_config_a;
         pad_config_b        <= next_pad_config_b;
         function_select_low <= next_function_select_low;
         wake_request        <= next_wake_request;
         reg_rdata           <= next_reg_rdata;
      end
   end

endmodule : gwc_regs

// >>> hdl/gwc_defines.svh
/*
 * Register offsets and reset values for the pin wake and
 * configuration register block. Assumes inclusion by bare name.
 */
`ifndef GWC_DEFINES_SVH
`define GWC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define GWC_OFS_PENDING_FLAGS      8'h40
`define GWC_OFS_TRIGGER_ENABLE     8'h34
`define GWC_OFS_TRIGGER_MODE       8'h28
`define GWC_OFS_TRIGGER_POLARITY   8'h2C
`define GWC_OFS_PENDING_FLAG_CLEAR 8'h48
`define GWC_OFS_WAKE_ENABLE        8'h4C
`define GWC_OFS_WAKE_ENABLE_SET    8'h50
`define GWC_OFS_WAKE_ENABLE_CLEAR  8'h54
`define GWC_OFS_BOTH_EDGE_SELECT   8'h5C
`define GWC_OFS_PAD_CONFIG_A       8'h60
`define GWC_OFS_PAD_CONFIG_B       8'h64
`define GWC_OFS_FUNCTION_SEL_LOW   8'h68

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define GWC_RST_ZERO               32'h0000_0000
`define GWC_RST_PAD_CONFIG_B       32'h0000_0000

`endif

// >>> hdl/gwc_pkg.sv
/*
 * Types shared by the pin wake and configuration register block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gwc_pkg;

   // Register bus request, one cycle per strobe
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } gwc_req_s;

   // Per-pin trigger configuration as seen by the detector
   typedef struct packed {
      logic enable;
      logic edge_mode;
      logic polarity;
      logic both_edges;
   } gwc_trig_s;

endpackage : gwc_pkg

// >>> hdl/gwc_sync.sv
/*
 * Two-flop synchroniser for a vector of pin levels.
 * Assumes the pins are asynchronous to clk_sys.
 */
`timescale 1ns/100ps
module gwc_sync #(
   parameter int WIDTH = 32
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   // ----------------------------------------------------------------------
   // First flop feeds only the second
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta     <= '0;
         sync_out <= '0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule : gwc_sync

// >>> hdl/gwc_detect.sv
/*
 * Per-pin interrupt condition detector: level or edge, polarity, dual edge.
 * Assumes synchronised pin levels on clk_sys.
 */
`timescale 1ns/100ps
module gwc_detect
   import gwc_pkg::*;
(
   input  wire logic      clk_sys,
   input  wire logic      rst,
   input  wire logic      pin_level,
   input  wire gwc_trig_s trig,
   output logic           hit
);

   logic prev;
   logic next_prev;

   // Previous level for edge detection
   always_comb begin
      next_prev = pin_level;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prev <= 1'b0;
      end else begin
         prev <= next_prev;
      end
   end

   // Condition decode; dual edge overrides polarity only in edge mode
   always_comb begin
      hit = 1'b0;
      if (trig.enable) begin
         if (!trig.edge_mode) begin
            hit = (pin_level == trig.polarity);                    // see R11
         end else if (trig.both_edges) begin
            hit = (pin_level != prev);                             // see R12
         end else begin
            hit = trig.polarity ? (pin_level & ~prev)              // see R11
                                : (~pin_level & prev);
         end
      end
   end

endmodule : gwc_detect

// >>> tb/gwc_regs_asserts.sv
/* Concurrent checks on the register block ports.
   Assumes binding to gwc_regs on one clock, async reset rst. */
`timescale 1ns/100ps
`include "gwc_defines.svh"
module gwc_regs_chk #(
   parameter int PINS = 32
) (
   input wire logic            clk_sys,
   input wire logic            rst,
   input wire logic [7:0]      reg_addr,
   input wire logic [31:0]     reg_wdata,
   input wire logic            reg_wr,
   input wire logic            reg_rd,
   input wire logic [31:0]     reg_rdata,
   input wire logic [PINS-1:0] wake_request,
   input wire logic [PINS-1:0] pending_flags,
   input wire logic [PINS-1:0] wake_enable,
   input wire logic [PINS-1:0] pad_config_a,
   input wire logic [PINS-1:0] function_select_low
);
   // ----------------------------------------------------------------
   // Register effects, one cycle after the strobe
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire logic [PINS-1:0] wd = reg_wdata[PINS-1:0];
   wire logic [PINS-1:0] keep_pf = pending_flags & ~wd;
   wire logic [PINS-1:0] wake_due = pending_flags & wake_enable;
   wire logic wr_wk = reg_wr && reg_addr == `GWC_OFS_WAKE_ENABLE;
   wire logic wr_set = reg_wr && reg_addr == `GWC_OFS_WAKE_ENABLE_SET;
   wire logic wr_clr = reg_wr && reg_addr == `GWC_OFS_WAKE_ENABLE_CLEAR;
   wire logic wr_pf = reg_wr && reg_addr == `GWC_OFS_PENDING_FLAG_CLEAR;
   wire logic wr_fs = reg_wr && reg_addr == `GWC_OFS_FUNCTION_SEL_LOW;
   wire logic wr_pa = reg_wr && reg_addr == `GWC_OFS_PAD_CONFIG_A;
   wire logic rd_wk = reg_rd && reg_addr == `GWC_OFS_WAKE_ENABLE;
   a_wake_write: assert property (wr_wk |=> wake_enable == $past(wd))
      else $error("wake enable write lost");
   a_wake_set_alias: assert property (
      wr_set |=> wake_enable == ($past(wake_enable) | $past(wd)))
      else $error("wake set alias wrong");
   a_wake_clear_alias: assert property (
      wr_clr |=> wake_enable == ($past(wake_enable) & ~$past(wd)))
      else $error("wake clear alias wrong");
   a_wake_hold: assert property (!(wr_wk || wr_set || wr_clr) |=> $stable(wake_enable))
      else $error("wake enable changed unasked");
   a_flag_zero_keep: assert property (
      wr_pf |=> (pending_flags & $past(keep_pf)) == $past(keep_pf))
      else $error("pending flag lost on zero bit");
   a_flag_sticky: assert property (
      !wr_pf |=> (pending_flags & $past(pending_flags)) == $past(pending_flags))
      else $error("pending flag dropped without clear");
   a_func_write: assert property (wr_fs |=> function_select_low == $past(wd))
      else $error("function select write lost");
   a_pad_write: assert property (wr_pa |=> pad_config_a == $past(wd))
      else $error("pad config write lost");
   a_read_wake: assert property (
      rd_wk |=> reg_rdata[PINS-1:0] == $past(wake_enable))
      else $error("wake enable read wrong");
   a_wake_request: assert property (##1 wake_request == $past(wake_due))
      else $error("wake request mismatch");
endmodule : gwc_regs_chk
bind gwc_regs gwc_regs_chk #(.PINS(PINS)) u_gwc_regs_chk (.clk_sys, .rst, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .wake_request, .pending_flags, .wake_enable, .pad_config_a,
   .function_select_low);

// >>> tb/gwc_pin_model.sv
/* Board side of the pins: drives the levels the bench commands.
   Assumes commands change right after a clock edge. */
`timescale 1ns/100ps
module gwc_pin_model (
   input  wire logic        clk_sys,
   input  wire logic [31:0] level_cmd,
   output logic      [31:0] pin_in
);
   // Pins are always driven by the board, so no release level exists
   always_ff @(posedge clk_sys) begin
      pin_in <= level_cmd;
   end
endmodule : gwc_pin_model

// >>> tb/gwc_regs_tb.sv
/* Self-checking bench for the wake and configuration registers.
   Assumes the design package, defines header and pin model. */
`timescale 1ns/100ps
`include "gwc_defines.svh"
module gwc_regs_tb
   import gwc_pkg::*;
;
   // ----------------------------------------------------------------
   // Clock, reset, design and board model
   // ----------------------------------------------------------------
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   gwc_req_s    req = '0;
   logic [31:0] level_cmd = 32'h0;
   logic [31:0] reg_rdata, pin_in, wake_request, pad_b;
   int          failures = 0;
   int          checks_done = 0;
   int          cycles = 0;
   always #2 clk_sys = ~clk_sys;
   gwc_pin_model u_gwc_pin_model (.clk_sys, .level_cmd, .pin_in);
   gwc_regs #(.PINS(32)) u_gwc_regs (.clk_sys, .rst, .reg_addr(req.addr),
      .reg_wdata(req.wdata), .reg_wr(req.wr), .reg_rd(req.rd), .reg_rdata, .pin_in,
      .wake_request, .pending_flags(), .wake_enable(), .pad_config_a(), .pad_config_b(pad_b),
      .function_select_low());
   // ----------------------------------------------------------------
   // Bus cycles and comparison
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys) req <= '{1'b1, 1'b0, a, d};
      @(posedge clk_sys) req <= '0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys) req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge clk_sys) req <= '0;
      #1 check(reg_rdata, exp);
   endtask : rd
   // Zero after reset, then a distinct pattern per register reads back
   task automatic t_plain_rw;
      logic [7:0] ofs [5];
      ofs = '{8'h4C, 8'h5C, 8'h60, 8'h64, 8'h68};
      foreach (ofs[i]) rd(ofs[i], 32'h0);
      foreach (ofs[i]) begin
         wr(ofs[i], 32'hA5C3_0F10 ^ i); // all 32 pins exist, so every bit may change
         rd(ofs[i], 32'hA5C3_0F10 ^ i);
      end
      check(pad_b, 32'hA5C3_0F13);
   endtask : t_plain_rw
   // Alias writes touch only the one bits; the set alias and a hole read zero
   task automatic t_wake_alias;
      wr(8'h4C, 32'h0000_00F0);
      wr(8'h50, 32'h0000_000F);
      rd(8'h4C, 32'h0000_00FF);
      wr(8'h54, 32'h0000_003C);
      rd(8'h4C, 32'h0000_00C3);
      rd(8'h50, 32'h0000_0000);
      wr(8'h7C, 32'hFFFF_FFFF);
      rd(8'h7C, 32'h0000_0000);
   endtask : t_wake_alias
   // Pin 0 rising edge, pin 1 both edges, pin 2 high level
   task automatic t_pin_events;
      wr(8'h5C, 32'h0000_0002);
      wr(8'h68, 32'h0000_0007); // must not mask detection
      wr(8'h28, 32'h0000_0003);
      wr(8'h2C, 32'h0000_0005);
      wr(8'h34, 32'h0000_0007);
      wr(8'h4C, 32'h0000_0002);
      rd(8'h40, 32'h0000_0000);
      @(posedge clk_sys) level_cmd <= 32'h0000_0007;
      repeat (8) @(posedge clk_sys);
      rd(8'h40, 32'h0000_0007);
      check(wake_request, 32'h0000_0002);
      wr(8'h48, 32'h0000_0001);
      rd(8'h40, 32'h0000_0006);
      wr(8'h48, 32'h0000_0006);
      rd(8'h40, 32'h0000_0004); // level still high re-arms
      @(posedge clk_sys) level_cmd <= 32'h0000_0000;
      repeat (8) @(posedge clk_sys);
      wr(8'h48, 32'h0000_0004);
      rd(8'h40, 32'h0000_0002);
      check(wake_request, 32'h0000_0002);
   endtask : t_pin_events
   // Pin 3 falling edge, pin 4 low level; the low level re-arms after a clear
   task automatic t_low_events;
      wr(8'h48, 32'hFFFF_FFFF);
      @(posedge clk_sys) level_cmd <= 32'h0000_0018;
      repeat (8) @(posedge clk_sys);
      wr(8'h28, 32'h0000_000B);
      wr(8'h34, 32'h0000_001F);
      rd(8'h40, 32'h0000_0000);
      @(posedge clk_sys) level_cmd <= 32'h0000_0000;
      repeat (8) @(posedge clk_sys);
      rd(8'h40, 32'h0000_0018);
      wr(8'h48, 32'h0000_0018);
      rd(8'h40, 32'h0000_0010);
   endtask : t_low_events
   // ----------------------------------------------------------------
   // Sequence, hang guard and verdict
   // ----------------------------------------------------------------
   task automatic end_of_test;
      if (failures == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test
   // The whole run needs about 130 cycles; the ceiling of 3000 leaves room
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         $display("Error at %0t: timeout", $time);
         end_of_test();
      end
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      t_plain_rw();
      t_wake_alias();
      t_pin_events();
      t_low_events();
      end_of_test();
   end
endmodule : gwc_regs_tb
